//--- include/dw_store_regs.vh
/*
 * constants for the doubleword store execution block: opcodes, fields,
 * register map and bit positions.
 * assumes it is included once by bare name from the design files.
 */
`ifndef DW_STORE_REGS_VH
`define DW_STORE_REGS_VH

// ==========================================================
// instruction encodings
`define OP_PRIMARY_X      6'h1f
`define OP_PRIMARY_DS     6'h3e
`define OP_PRIMARY_FD     6'h36
`define OP_PRIMARY_FDU    6'h37
`define XO_STORE_COND     10'h0d6
`define XO_STORE_UX       10'h0b5
`define XO_STORE_X        10'h095
`define DS_LOW_PLAIN      2'h0
`define DS_LOW_UPDATE     2'h1

// ==========================================================
// wishbone register map (byte offsets)
`define REG_CTRL          4'h0
`define REG_STATUS        4'h4
`define REG_IRQ_STAT      4'h8
`define REG_IRQ_MASK      4'hc

// ctrl bits
`define CTRL_MODE64       0
`define CTRL_ALIGN_TRAP   1
`define CTRL_RESET_VAL    2'h3

// event bits (irq status and mask)
`define EV_ILLEGAL        0
`define EV_INVALID_FORM   1
`define EV_ALIGN          2
`define EV_STORE_FAIL     3
`define EV_RESV_SNOOP     4
`define EV_WIDTH          5

// status bits
`define ST_RESV_VALID     0
`define ST_BUSY           1
`define ST_LAST_CR0_LO    4

// ==========================================================
// condition field bits
`define CR0_SUCCESS       3'h1
`define CR0_FAIL          3'h0

`endif

//--- hw/ea_calc.v
/*
 * effective address generator for the doubleword stores.
 * assumes operands are stable for the cycle it is used in.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dw_store_regs.vh"

module ea_calc #(
    parameter XLEN = 64
) (
    input wire [XLEN-1:0] base_val_i,
    input wire [XLEN-1:0] index_val_i,
    input wire [15:0] imm_i,
    input wire use_index_i,
    input wire scale_ds_i,
    input wire base_zero_i,
    output wire [XLEN-1:0] effective_address_o
);
    wire [XLEN-1:0] disp;
    wire [XLEN-1:0] offset;
    wire [XLEN-1:0] base_term;

    // [RULE9] ds field times four
    assign disp = scale_ds_i ?
        {{(XLEN-16){imm_i[15]}}, imm_i[15:2], 2'b00} :
        {{(XLEN-16){imm_i[15]}}, imm_i};
    assign offset = use_index_i ? index_val_i : disp;
    // [RULE14] base of zero means no base
    assign base_term = base_zero_i ? {XLEN{1'b0}} : base_val_i;
    assign effective_address_o = base_term + offset;
endmodule // ea_calc

//--- hw/resv_unit.v
/*
 * reservation holder: valid flag plus doubleword address.
 * assumes set and clear pulses are single-cycle and synchronous.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dw_store_regs.vh"

module resv_unit #(
    parameter XLEN = 64
) (
    input wire clk_i,
    input wire rst_i,
    input wire set_i,
    input wire [XLEN-1:0] set_addr_i,
    input wire clear_i,
    input wire snoop_valid_i,
    input wire [XLEN-1:0] snoop_addr_i,
    input wire [XLEN-1:0] cmp_addr_i,
    output reg valid_o,
    output wire match_o,
    output wire snoop_hit_o
);
    reg [XLEN-4:0] addr;

    // [RULE18] doubleword granular compare
    assign match_o = valid_o && (addr == cmp_addr_i[XLEN-1:3]);
    assign snoop_hit_o = snoop_valid_i && valid_o && (addr == snoop_addr_i[XLEN-1:3]);

    always @(posedge clk_i) begin
        if (rst_i) begin
            valid_o <= 1'b0;
            addr <= {(XLEN-3){1'b0}};
        end else if (set_i) begin
            // [RULE7] new reservation replaces old
            valid_o <= 1'b1;
            addr <= set_addr_i[XLEN-1:3];
        end else if (clear_i || snoop_hit_o) begin
            // [RULE7] store conditional or foreign store
            valid_o <= 1'b0;
        end
    end
endmodule // resv_unit

//--- hw/dw_store_exec.v
/*
 * doubleword store decoder and executor with wishbone control registers.
 * assumes one instruction at a time, operands presented with issue_i,
 * and a memory port that accepts a request and later pulses mem_done_i.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dw_store_regs.vh"

// Functional notes
// [RULE1] matching reservation: store and clear
// [RULE2] mismatching reservation: clear, no store
// [RULE3] no reservation: complete without writing
// [RULE4] cr0 bits 0-2 report store success
// [RULE5] summary overflow copied to cr0 bit 3
// [RULE6] misaligned conditional store raises alignment; code raises it only while the ctrl align trap bit is set
// [RULE7] reservation cleared by reserve, conditional, snoop
// [RULE8] 32-bit mode traps doubleword stores illegal
// [RULE9] update ds form scales displacement by four
// [RULE10] update ds form writes address back
// [RULE11] update ds with zero base invalid
// [RULE12] indexed update stores and writes base
// [RULE13] indexed update with zero base invalid
// [RULE14] indexed store, zero base uses index
// [RULE15] float store at base plus displacement
// [RULE16] float update writes base only without fault; code also skips the write for a zero base
// [RULE17] float stores leave cr0 and fpscr alone
// [RULE18] reservation is flag plus doubleword address
module dw_store_exec #(
    parameter XLEN = 64
) (
    input wire clk_i,
    input wire rst_i,
    // instruction issue
    input wire issue_i,
    input wire [31:0] instr_i,
    input wire [XLEN-1:0] base_val_i,
    input wire [XLEN-1:0] index_val_i,
    input wire [XLEN-1:0] source_gpr_val_i,
    input wire [63:0] source_fpr_val_i,
    input wire summary_overflow_i,
    output reg ready_o,
    output reg done_o,
    // load-and-reserve from elsewhere in the core
    input wire resv_set_i,
    input wire [XLEN-1:0] resv_addr_i,
    // snooped stores from other agents
    input wire snoop_valid_i,
    input wire [XLEN-1:0] snoop_addr_i,
    // data storage
    output reg mem_req_o,
    output reg [XLEN-1:0] mem_addr_o,
    output reg [63:0] mem_data_o,
    input wire mem_done_i,
    input wire mem_fault_i,
    // register file write back
    output reg gpr_we_o,
    output reg [4:0] gpr_waddr_o,
    output reg [XLEN-1:0] gpr_wdata_o,
    output reg cr0_we_o,
    output reg [3:0] cr0_o,
    // exceptions
    output reg illegal_o,
    output reg invalid_form_o,
    output reg align_o,
    output reg dsi_o,
    // wishbone
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg irq_o
);
    // ==========================================================
    // decode
    localparam S_IDLE = 2'h0;
    localparam S_MEM = 2'h1;
    localparam S_DONE = 2'h2;

    wire [5:0] primary = instr_i[31:26];
    wire [4:0] source_gpr_sel = instr_i[25:21];
    wire [4:0] base_gpr_sel = instr_i[20:16];
    wire [9:0] xo = instr_i[10:1];
    wire rc = instr_i[0];
    wire [1:0] ds_low = instr_i[1:0];
    wire base_zero = (base_gpr_sel == 5'h00);

    wire is_cond = (primary == `OP_PRIMARY_X) && (xo == `XO_STORE_COND) && rc;
    wire is_ux = (primary == `OP_PRIMARY_X) && (xo == `XO_STORE_UX) && !rc;
    wire is_x = (primary == `OP_PRIMARY_X) && (xo == `XO_STORE_X) && !rc;
    wire is_ds = (primary == `OP_PRIMARY_DS) && (ds_low == `DS_LOW_PLAIN);
    wire is_dsu = (primary == `OP_PRIMARY_DS) && (ds_low == `DS_LOW_UPDATE);
    wire is_fd = (primary == `OP_PRIMARY_FD);
    wire is_fdu = (primary == `OP_PRIMARY_FDU);
    wire is_int = is_cond | is_ux | is_x | is_ds | is_dsu;
    wire is_fp = is_fd | is_fdu;

    wire [XLEN-1:0] effective_address;
    ea_calc #(.XLEN(XLEN)) u_ea (
        .base_val_i(base_val_i),
        .index_val_i(index_val_i),
        .imm_i(instr_i[15:0]),
        .use_index_i(is_cond | is_ux | is_x),
        .scale_ds_i(is_ds | is_dsu),
        .base_zero_i(base_zero),
        .effective_address_o(effective_address)
    );

    // ==========================================================
    // control registers
    reg [1:0] ctrl;
    reg [5:0] irq_stat;
    reg [5:0] irq_mask;
    reg [3:0] last_cr0;
    reg [1:0] state;
    reg [5:0] ev;
    reg resv_clear;
    wire resv_valid;
    wire resv_match;
    wire snoop_hit;
    wire mode64 = ctrl[`CTRL_MODE64];

    resv_unit #(.XLEN(XLEN)) u_resv (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(resv_set_i),
        .set_addr_i(resv_addr_i),
        .clear_i(resv_clear),
        .snoop_valid_i(snoop_valid_i),
        .snoop_addr_i(snoop_addr_i),
        .cmp_addr_i(effective_address),
        .valid_o(resv_valid),
        .match_o(resv_match),
        .snoop_hit_o(snoop_hit)
    );

    // ==========================================================
    // execution
    reg upd_pending;
    reg cond_pending;
    reg [XLEN-1:0] held_ea;
    reg [4:0] held_base;

    always @(posedge clk_i) begin
        if (rst_i) begin
            state <= S_IDLE;
            ready_o <= 1'b1;
            done_o <= 1'b0;
            mem_req_o <= 1'b0;
            mem_addr_o <= {XLEN{1'b0}};
            mem_data_o <= 64'h0;
            gpr_we_o <= 1'b0;
            gpr_waddr_o <= 5'h00;
            gpr_wdata_o <= {XLEN{1'b0}};
            cr0_we_o <= 1'b0;
            cr0_o <= 4'h0;
            illegal_o <= 1'b0;
            invalid_form_o <= 1'b0;
            align_o <= 1'b0;
            dsi_o <= 1'b0;
            upd_pending <= 1'b0;
            cond_pending <= 1'b0;
            held_ea <= {XLEN{1'b0}};
            held_base <= 5'h00;
            last_cr0 <= 4'h0;
            resv_clear <= 1'b0;
            ev <= 6'h00;
        end else begin
            done_o <= 1'b0;
            gpr_we_o <= 1'b0;
            cr0_we_o <= 1'b0;
            illegal_o <= 1'b0;
            invalid_form_o <= 1'b0;
            align_o <= 1'b0;
            dsi_o <= 1'b0;
            resv_clear <= 1'b0;
            ev <= 6'h00;
            case (state)
                S_IDLE: begin
                    if (issue_i && (is_int || is_fp)) begin
                        held_ea <= effective_address;
                        held_base <= base_gpr_sel;
                        mem_addr_o <= effective_address;
                        mem_data_o <= is_fp ? source_fpr_val_i : source_gpr_val_i;
                        ready_o <= 1'b0;
                        state <= S_DONE;
                        if (is_int && !mode64) begin
                            // [RULE8] doubleword stores illegal in 32-bit mode
                            illegal_o <= 1'b1;
                            ev[`EV_ILLEGAL] <= 1'b1;
                        end else if ((is_dsu || is_ux) && base_zero) begin
                            // [RULE11] [RULE13] zero base with update
                            invalid_form_o <= 1'b1;
                            ev[`EV_INVALID_FORM] <= 1'b1;
                        end else if (is_cond) begin
                            // [RULE7] any conditional store not trapped as illegal clears reservation
                            resv_clear <= 1'b1;
                            // [RULE5] summary overflow to bit 3 position
                            cr0_o <= {3'b000, summary_overflow_i};
                            if (effective_address[2:0] != 3'h0 && ctrl[`CTRL_ALIGN_TRAP]) begin
                                // [RULE6] misaligned: alignment exception
                                align_o <= 1'b1;
                                ev[`EV_ALIGN] <= 1'b1;
                            end else if (resv_match) begin
                                // [RULE1] matching reservation stores
                                mem_req_o <= 1'b1;
                                cond_pending <= 1'b1;
                                state <= S_MEM;
                            end else begin
                                // [RULE2] [RULE3] no store, report failure
                                // [RULE4] failure code in cr0
                                cr0_o <= {`CR0_FAIL, summary_overflow_i};
                                cr0_we_o <= 1'b1;
                                last_cr0 <= {`CR0_FAIL, summary_overflow_i};
                                ev[`EV_STORE_FAIL] <= 1'b1;
                            end
                        end else begin
                            // [RULE9] [RULE12] [RULE14] [RULE15] plain store
                            mem_req_o <= 1'b1;
                            // [RULE10] [RULE12] [RULE16] update after store
                            upd_pending <= is_dsu | is_ux | (is_fdu & !base_zero);
                            state <= S_MEM;
                        end
                    end
                end
                S_MEM: begin
                    if (mem_done_i) begin
                        mem_req_o <= 1'b0;
                        state <= S_DONE;
                        upd_pending <= 1'b0;
                        cond_pending <= 1'b0;
                        if (mem_fault_i) begin
                            // [RULE16] fault suppresses base update
                            dsi_o <= 1'b1;
                        end else if (upd_pending) begin
                            gpr_we_o <= 1'b1;
                            gpr_waddr_o <= held_base;
                            gpr_wdata_o <= held_ea;
                        end
                        if (cond_pending) begin
                            // [RULE4] success code when performed
                            cr0_o <= {mem_fault_i ? `CR0_FAIL : `CR0_SUCCESS, cr0_o[0]};
                            cr0_we_o <= 1'b1;
                            last_cr0 <= {mem_fault_i ? `CR0_FAIL : `CR0_SUCCESS, cr0_o[0]};
                        end
                        // [RULE17] float stores never touch cr0
                    end
                end
                S_DONE: begin
                    done_o <= 1'b1;
                    ready_o <= 1'b1;
                    state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
            if (snoop_hit) begin
                ev[`EV_RESV_SNOOP] <= 1'b1;
            end
        end
    end

    // ==========================================================
    // wishbone slave, one wait cycle, ack drops after one
    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wb_wr = wb_req && wb_we_i && wb_sel_i[0];

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            ctrl <= `CTRL_RESET_VAL;
            irq_mask <= 6'h00;
            irq_stat <= 6'h00;
            irq_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
            // set wins over write-one-to-clear
            irq_stat <= (irq_stat & ~((wb_wr && wb_adr_i == `REG_IRQ_STAT) ?
                wb_dat_i[5:0] : 6'h00)) | ev;
            irq_o <= |(irq_stat & irq_mask);
            if (wb_wr && wb_adr_i == `REG_CTRL) begin
                ctrl <= wb_dat_i[1:0];
            end
            if (wb_wr && wb_adr_i == `REG_IRQ_MASK) begin
                irq_mask <= wb_dat_i[5:0];
            end
            if (wb_req) begin
                case (wb_adr_i)
                    `REG_CTRL: wb_dat_o <= {30'h0, ctrl};
                    `REG_STATUS: wb_dat_o <= {24'h0, last_cr0, 2'h0, ~ready_o, resv_valid};
                    `REG_IRQ_STAT: wb_dat_o <= {26'h0, irq_stat};
                    `REG_IRQ_MASK: wb_dat_o <= {26'h0, irq_mask};
                    default: wb_dat_o <= 32'h0;
                endcase
            end
        end
    end
endmodule // dw_store_exec
`default_nettype wire

//--- test/dw_store_exec_properties.sv
/* checker for dw_store_exec port timing and results.
   assumes it is bound to the top module and sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module dw_store_exec_properties #(parameter XLEN = 64) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] instr_i,
    input wire logic [63:0] source_fpr_val_i,
    input wire logic ready_o,
    input wire logic done_o,
    input wire logic mem_req_o,
    input wire logic [XLEN-1:0] mem_addr_o,
    input wire logic [63:0] mem_data_o,
    input wire logic mem_done_i,
    input wire logic mem_fault_i,
    input wire logic gpr_we_o,
    input wire logic cr0_we_o,
    input wire logic [3:0] cr0_o,
    input wire logic illegal_o,
    input wire logic invalid_form_o,
    input wire logic align_o
);
// ==========================================
// helpers: opcode and operand at the take edge
logic prev_fp;
logic [63:0] prev_fpr;
always @(posedge clk_i) begin
    prev_fp <= instr_i[31:27] == 5'h1b;
    prev_fpr <= source_fpr_val_i;
end
default clocking cb @(posedge clk_i); endclocking
default disable iff (rst_i);
// ==========================================
// assertions
req_hold_a: assert property (mem_req_o && !mem_done_i |=> mem_req_o
    && $stable(mem_addr_o) && $stable(mem_data_o)) else $error("request not held");
busy_req_a: assert property (mem_req_o |-> !ready_o) else $error("ready during access");
illegal_trap_a: assert property (illegal_o |-> !mem_req_o && !gpr_we_o ##1 done_o)
    else $error("illegal trap wrong");
invalid_trap_a: assert property (invalid_form_o |-> !mem_req_o ##1 done_o)
    else $error("invalid form wrong");
align_trap_a: assert property (align_o |-> !mem_req_o ##1 done_o)
    else $error("alignment trap wrong");
cr0_bits_a: assert property (cr0_we_o |-> cr0_o[3:2] == 2'b00)
    else $error("cr0 high bits set");
cr0_ok_a: assert property (cr0_we_o && cr0_o[1] |-> $past(mem_done_i) && !$past(mem_fault_i))
    else $error("success without store");
upd_fault_a: assert property (gpr_we_o |-> $past(mem_done_i) && !$past(mem_fault_i) ##1 done_o)
    else $error("update after fault");
fpr_data_a: assert property ($rose(mem_req_o) && prev_fp |-> mem_data_o == prev_fpr)
    else $error("float data wrong");
cover property (cr0_we_o && cr0_o[1]);
cover property (gpr_we_o);
cover property (illegal_o);
endmodule // dw_store_exec_properties
bind dw_store_exec dw_store_exec_properties #(.XLEN(XLEN)) i_dw_store_exec_properties (
    .clk_i, .rst_i, .instr_i, .source_fpr_val_i, .ready_o, .done_o, .mem_req_o,
    .mem_addr_o, .mem_data_o, .mem_done_i, .mem_fault_i, .gpr_we_o, .cr0_we_o, .cr0_o,
    .illegal_o, .invalid_form_o, .align_o);
`default_nettype wire

//--- test/mem_model.sv
/* data storage model: answers each request lat_i + 1 cycles after it is raised.
   assumes the request stays up until it sees the done pulse. */
`timescale 1ns/1ps
`default_nettype none
module mem_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic mem_req_i,
    input wire logic [63:0] mem_addr_i,
    input wire logic [63:0] mem_data_i,
    input wire logic [3:0] lat_i,
    input wire logic fault_i,
    output logic mem_done_o,
    output logic mem_fault_o,
    output logic [63:0] last_addr_o,
    output logic [63:0] last_data_o,
    output int wr_cnt_o
);
logic [3:0] cnt;
always @(posedge clk_i) begin
    mem_done_o <= 1'b0;
    mem_fault_o <= 1'b0;
    if (rst_i) begin
        cnt <= 4'h0;
        wr_cnt_o <= 0;
    end else if (mem_req_i && !mem_done_o) begin
        cnt <= cnt + 4'h1;
        if (cnt == lat_i) begin
            // faulted access leaves memory alone
            cnt <= 4'h0;
            mem_done_o <= 1'b1;
            mem_fault_o <= fault_i;
            if (!fault_i) begin
                last_addr_o <= mem_addr_i;
                last_data_o <= mem_data_i;
                wr_cnt_o <= wr_cnt_o + 1;
            end
        end
    end
end
endmodule // mem_model
`default_nettype wire

//--- test/dw_store_exec_tb.sv
/* bench for dw_store_exec: table of stores, then reservation, trap,
   interrupt and reset cases. assumes mem_model on the memory port. */
`timescale 1ns/1ps
`default_nettype none
`include "dw_store_regs.vh"
module dw_store_exec_tb;
logic clk_i, rst_i, issue_i, resv_set_i, snoop_valid_i, so, fault, wb_cyc_i, wb_stb_i, wb_we_i;
logic ready_o, done_o, mem_req_o, mem_done_i, mem_fault_i, gpr_we_o, cr0_we_o, wb_ack_o, irq_o;
logic illegal_o, invalid_form_o, align_o, dsi_o;
logic [31:0] instr_i, wb_dat_i, wb_dat_o, rd, sc;
logic [63:0] base_val_i, index_val_i, resv_addr_i, snoop_addr_i, mem_addr_o, mem_data_o;
logic [63:0] gpr_wdata_o, last_a, last_d;
logic [3:0] wb_adr_i, cr0_o, lat;
logic [4:0] gpr_waddr_o;
logic [5:0] ev;
int error_cnt, comparisons, wcnt, w0;
localparam logic [63:0] src_val = 64'h0123_4567_89ab_cdef;
localparam logic [63:0] fpr_val = 64'hfedc_ba98_7654_3210;
typedef struct {logic [31:0] i; logic [63:0] b, x, a; logic w; logic [5:0] e;} row_t;
row_t rows [11];
dw_store_exec #(.XLEN(64)) i_dw_store_exec (.clk_i, .rst_i, .issue_i, .instr_i, .base_val_i,
    .index_val_i, .source_gpr_val_i(src_val), .source_fpr_val_i(fpr_val),
    .summary_overflow_i(so), .ready_o, .done_o, .resv_set_i, .resv_addr_i, .snoop_valid_i,
    .snoop_addr_i, .mem_req_o, .mem_addr_o, .mem_data_o, .mem_done_i, .mem_fault_i,
    .gpr_we_o, .gpr_waddr_o, .gpr_wdata_o, .cr0_we_o, .cr0_o, .illegal_o, .invalid_form_o,
    .align_o, .dsi_o, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i(4'hf),
    .wb_dat_o, .wb_ack_o, .irq_o);
mem_model i_mem_model (.clk_i, .rst_i, .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o),
    .mem_data_i(mem_data_o), .lat_i(lat), .fault_i(fault), .mem_done_o(mem_done_i),
    .mem_fault_o(mem_fault_i), .last_addr_o(last_a), .last_data_o(last_d), .wr_cnt_o(wcnt));
initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
end
// pulses seen since the last issue: {dsi,align,illegal,invalid,cr0,gpr}
always @(posedge clk_i) ev <= issue_i ? 6'h0 : ev | {dsi_o, align_o, illegal_o,
    invalid_form_o, cr0_we_o, gpr_we_o};
// ==========================================
// tasks
task automatic stop_test;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
endtask
task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
        error_cnt++;
        $display("unexpected at %0t: %s", $time, m);
    end
endtask
task automatic hang(input int n);
    if (n >= 60) begin
        chk(1'b0, "no answer");
        stop_test;
    end
endtask
task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 60) begin
        @(posedge clk_i);
        n++;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
    hang(n);
endtask
task automatic run(input logic [31:0] ins, input logic [63:0] b, x);
    int n;
    n = 0;
    w0 = wcnt;
    instr_i <= ins;
    base_val_i <= b;
    index_val_i <= x;
    issue_i <= 1'b1;
    @(posedge clk_i);
    issue_i <= 1'b0;
    while (done_o !== 1'b1 && n < 60) begin
        @(posedge clk_i);
        n++;
    end
    @(posedge clk_i);
    hang(n);
endtask
task automatic poke(input logic s, input logic [63:0] a);
    resv_set_i <= !s;
    snoop_valid_i <= s;
    resv_addr_i <= a;
    snoop_addr_i <= a;
    @(posedge clk_i);
    resv_set_i <= 1'b0;
    snoop_valid_i <= 1'b0;
    @(posedge clk_i);
endtask
task automatic verify(input logic w, input logic [5:0] e, input logic [63:0] a, d,
    input logic [3:0] c);
    chk(wcnt - w0 == int'(w), "write count");
    if (w) chk(last_a === a && last_d === d, "store address or data");
    chk(ev === e, "event pulses");
    if (e[1]) chk(cr0_o === c, "condition field");
    if (e[0]) chk(gpr_wdata_o === a && gpr_waddr_o === instr_i[20:16], "base update");
endtask
function automatic logic [31:0] xf(input logic [9:0] xo, input logic [4:0] ra);
    return {`OP_PRIMARY_X, 5'd3, ra, 5'd4, xo, xo == `XO_STORE_COND};
endfunction
// ==========================================
// main sequence
initial begin
    {rst_i, issue_i, resv_set_i, snoop_valid_i, wb_cyc_i, wb_stb_i, wb_we_i} = 7'h40;
    {so, fault, instr_i, wb_dat_i, wb_adr_i, lat} = '0;
    {base_val_i, index_val_i, resv_addr_i, snoop_addr_i} = '0;
    sc = xf(`XO_STORE_COND, 5'd5);
    rows[0] = '{xf(`XO_STORE_X, 0), 64'h1000, 64'h2000, 64'h2000, 1, 6'h00};
    rows[1] = '{xf(`XO_STORE_X, 5), 64'h1000, 64'h2000, 64'h3000, 1, 6'h00};
    rows[2] = '{xf(`XO_STORE_UX, 5), 64'h1000, 64'h2000, 64'h3000, 1, 6'h01};
    rows[3] = '{xf(`XO_STORE_UX, 0), 64'h1000, 64'h2000, 64'h0, 0, 6'h04};
    rows[4] = '{{`OP_PRIMARY_DS, 10'h66, 14'h3fff, 2'h1}, 64'h1000, 0, 64'hffc, 1, 6'h01};
    rows[5] = '{{`OP_PRIMARY_DS, 10'h60, 14'h0002, 2'h1}, 64'h1000, 0, 64'h0, 0, 6'h04};
    rows[6] = '{{`OP_PRIMARY_DS, 10'h60, 14'h0002, 2'h0}, 64'h1000, 0, 64'h8, 1, 6'h00};
    rows[7] = '{{`OP_PRIMARY_FD, 10'h47, 16'hfff8}, 64'h2000, 0, 64'h1ff8, 1, 6'h00};
    rows[8] = '{{`OP_PRIMARY_FDU, 10'h47, 16'h0010}, 64'h2000, 0, 64'h2010, 1, 6'h01};
    rows[9] = '{{`OP_PRIMARY_FDU, 10'h40, 16'h0020}, 64'h2000, 0, 64'h20, 1, 6'h00};
    rows[10] = '{sc, 64'h1000, 64'h2000, 64'h0, 0, 6'h02};
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    so <= 1'b1;
    foreach (rows[k]) begin
        lat <= k[3:0] % 4'h4;
        run(rows[k].i, rows[k].b, rows[k].x);
        verify(rows[k].w, rows[k].e, rows[k].a, rows[k].i[31:27] == 5'h1b ? fpr_val : src_val, 4'h1);
    end
    so <= 1'b0;
    poke(1'b0, 64'h3000);
    run(sc, 64'h1000, 64'h2000);
    verify(1'b1, 6'h02, 64'h3000, src_val, 4'h2);
    so <= 1'b1;
    run(sc, 64'h1000, 64'h2000);
    verify(1'b0, 6'h02, 0, 0, 4'h1);
    poke(1'b0, 64'h3000);
    run(sc, 64'h1000, 64'h2008);
    verify(1'b0, 6'h02, 0, 0, 4'h1);
    run(sc, 64'h1000, 64'h2000);
    verify(1'b0, 6'h02, 0, 0, 4'h1);
    poke(1'b0, 64'h3000);
    poke(1'b1, 64'h3004);
    run(sc, 64'h1000, 64'h2000);
    verify(1'b0, 6'h02, 0, 0, 4'h1);
    poke(1'b0, 64'h3000);
    run(sc, 64'h1000, 64'h2004);
    chk(ev[4] === 1'b1 && wcnt == w0, "misaligned store");
    fault <= 1'b1;
    run(rows[8].i, 64'h2000, 0);
    verify(1'b0, 6'h20, 0, 0, 4'h0);
    fault <= 1'b0;
    wb(1'b1, `REG_CTRL, 32'h2);
    run(rows[1].i, 64'h1000, 64'h2000);
    verify(1'b0, 6'h08, 0, 0, 4'h0);
    wb(1'b0, `REG_CTRL, 0);
    chk(rd[1:0] === 2'h2 && irq_o === 1'b0, "ctrl or masked irq");
    wb(1'b1, `REG_CTRL, 32'h3);
    wb(1'b1, `REG_IRQ_MASK, 32'h8);
    chk(irq_o === 1'b1, "irq not raised");
    wb(1'b0, `REG_IRQ_STAT, 0);
    chk(rd[4:0] === 5'h1f, "irq status");
    wb(1'b1, `REG_IRQ_STAT, 32'h8);
    wb(1'b0, `REG_IRQ_STAT, 0);
    chk(rd[4:0] === 5'h17 && irq_o === 1'b0, "irq clear");
    wb(1'b0, 4'h2, 0);
    chk(rd === 32'h0, "unmapped read");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `REG_IRQ_MASK, 0);
    chk(rd === 32'h0 && ready_o === 1'b1, "mask after reset");
    wb(1'b0, `REG_CTRL, 0);
    chk(rd[1:0] === `CTRL_RESET_VAL, "ctrl after reset");
    stop_test;
end
endmodule // dw_store_exec_tb
`default_nettype wire
